// >>> inc/adc_cal_consts.svh
`ifndef ADC_CAL_CONSTS_SVH
`define ADC_CAL_CONSTS_SVH

// core clock rate and timing figures
`define CORE_MHZ 25
`define ACQ_NS 235
`define ACQ_CYC ((`ACQ_NS * `CORE_MHZ + 999) / 1000)

// serial clock half period in core cycles, and the setup before fall one
`define HALF_CYC 5'h08
`define SETUP_CYC 5'h10

// serial clock fall counts within a frame
`define PWR_CAL_FALLS 6'h10
`define NORM_CAL_START 6'h11
`define NORM_CAL_END 6'h20
`define DATA_FALLS 6'h0C
`define FALLS_MAX 6'h3F
`define NORMAL_FALLS 6'h0C

// result coding
`define CODE_MAX 10'h3FF
`define CODE_MIN 10'h000

// synchroniser reset levels (link idles high)
`define SYNC_IDLE 3'h7

`endif

// >>> inc/adc_cal_pkg.sv
package adc_cal_pkg;

	typedef enum logic {
		DEV_IDLE = 1'b0,
		DEV_FRAME = 1'b1
	} dev_phase_type;

	typedef enum logic [2:0] {
		HOST_IDLE = 3'h0,
		HOST_SETUP = 3'h1,
		HOST_LOW = 3'h3,
		HOST_HIGH = 3'h2,
		HOST_GAP = 3'h6
	} host_phase_type;

	typedef struct packed {
		logic [2:0] sync;
		logic level;
	} pin_sync_state_type;

	typedef struct packed {
		dev_phase_type phase;
		logic first;
		logic [5:0] falls;
		logic [11:0] shreg;
		logic sdo;
		logic sdo_oe;
		logic [9:0] offset_correction_store;
		logic [9:0] code;
		logic cal_busy;
		logic cal_done;
	} dev_state_type;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic [2:0] sdo_sync;
		logic sdo_f;
		host_phase_type phase;
		logic [4:0] cnt;
		logic [5:0] falls;
		logic [5:0] target;
		logic first;
		logic [11:0] shreg;
		logic [9:0] result;
		logic valid;
		logic busy;
	} host_state_type;

endpackage : adc_cal_pkg

// >>> inc/adc_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface adc_link_if;
	logic cs_n;
	logic sclk;
	logic sdo;
	logic sdo_oe;

	modport dev (
		input cs_n,
		input sclk,
		output sdo,
		output sdo_oe
	);

	modport host (
		output cs_n,
		output sclk,
		input sdo,
		input sdo_oe
	);
endinterface : adc_link_if
`default_nettype wire

// >>> core/adc_host_end.sv
`timescale 1ns/1ns
`default_nettype none
`include "adc_cal_consts.svh"
module adc_host_end
	import adc_cal_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// serial link
	adc_link_if.host LINK,
	// user requests
	input wire logic START,
	input wire logic CAL_REQ,
	// user results
	output logic BUSY,
	output logic [9:0] RESULT,
	output logic RESULT_VALID
);

	host_state_type st_q;
	host_state_type st_d;

	always_comb begin
		st_d = st_q;
		st_d.valid = 1'b0;
		st_d.sdo_sync = {st_q.sdo_sync[1:0], LINK.sdo};
		if (st_q.sdo_sync[1] == st_q.sdo_sync[2]) begin
			st_d.sdo_f = st_q.sdo_sync[2];
		end
		st_d.cnt = st_q.cnt + 5'h01;
		unique case (st_q.phase)
			HOST_IDLE: begin
				st_d.cnt = 5'h00;
				if (START) begin
					// 32 falls give the device 15 periods of calibration
					if (st_q.first || CAL_REQ) begin // RL6 RL12 RL13
						st_d.target = `NORM_CAL_END;
					end else begin
						st_d.target = `NORMAL_FALLS;
					end
					st_d.cs_n = 1'b0;
					st_d.busy = 1'b1;
					st_d.falls = 6'h00;
					st_d.phase = HOST_SETUP;
				end
			end
			HOST_SETUP: begin
				if (st_q.cnt == `SETUP_CYC - 5'h01) begin
					st_d.cnt = 5'h00;
					st_d.shreg = {st_q.shreg[10:0], st_q.sdo_f};
					st_d.sclk = 1'b0;
					st_d.falls = 6'h01;
					st_d.phase = HOST_LOW;
				end
			end
			HOST_LOW: begin
				// sclk stays far below the calibration limit
				if (st_q.cnt == `HALF_CYC - 5'h01) begin // RL11
					st_d.cnt = 5'h00;
					st_d.sclk = 1'b1;
					st_d.phase = HOST_HIGH;
				end
			end
			HOST_HIGH: begin
				if (st_q.cnt == `HALF_CYC - 5'h01) begin
					st_d.cnt = 5'h00;
					if (st_q.falls == st_q.target) begin
						st_d.cs_n = 1'b1;
						st_d.phase = HOST_GAP;
						st_d.first = 1'b0;
						if (!st_q.first) begin
							st_d.result = st_q.shreg[9:0];
							st_d.valid = 1'b1;
						end
					end else begin
						if (st_q.falls < `DATA_FALLS) begin
							st_d.shreg = {st_q.shreg[10:0], st_q.sdo_f};
						end
						st_d.sclk = 1'b0;
						st_d.falls = st_q.falls + 6'h01;
						st_d.phase = HOST_LOW;
					end
				end
			end
			HOST_GAP: begin
				// chip select stays high for the acquisition interval
				if (st_q.cnt == 5'(`ACQ_CYC - 1)) begin // RL3
					st_d.busy = 1'b0;
					st_d.phase = HOST_IDLE;
				end
			end
			default: begin
				st_d.phase = HOST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			st_q <= '0;
			st_q.cs_n <= 1'b1;
			st_q.sclk <= 1'b1;
			st_q.first <= 1'b1;
			st_q.phase <= HOST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign LINK.cs_n = st_q.cs_n;
	assign LINK.sclk = st_q.sclk;
	assign BUSY = st_q.busy;
	assign RESULT = st_q.result;
	assign RESULT_VALID = st_q.valid;

endmodule : adc_host_end
`default_nettype wire

// >>> core/adc_device_end.sv
// How it works
// (RL1) first frame calibrates after sixteen serial falls
// (RL2) output held low during power-up calibration
// (RL3) host waits acquisition interval after calibration
// (RL4) short first frame leaves offset store unchanged
// (RL5) later samples corrected by stored offset
// (RL6) thirty-two falls in a frame mean calibration
// (RL7) first twelve clocks convert and shift result
// (RL8) calibration runs from fall seventeen to thirty-two
// (RL9) output low after twelve falls, released on deselect
// (RL10) short normal frame keeps previous offset
// (RL11) host keeps serial clock below calibration limit
// (RL12) host grants fifteen periods at power-up
// (RL13) host grants fifteen periods before deselect
// (RL14) offset store zero at power-up, never readable
// (RL15) two leading zeros, then result on falls
// (RL16) result is ten-bit straight binary
// (RL17) fall counter per frame, power-up first-frame flag
`timescale 1ns/1ns
`default_nettype none
`include "adc_cal_consts.svh"
module link_pin_sync
	import adc_cal_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// raw pin
	input wire logic PIN,
	// filtered level and its edges, one cycle each
	output logic LEVEL,
	output logic FELL,
	output logic ROSE
);

	pin_sync_state_type st_q;
	pin_sync_state_type st_d;

	// stage one feeds stage two only; stages two and three must agree
	always_comb begin
		st_d = st_q;
		st_d.sync = {st_q.sync[1:0], PIN};
		if (st_q.sync[1] == st_q.sync[2]) begin
			st_d.level = st_q.sync[2];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			// link idles high, so no false edge follows reset
			st_q.sync <= `SYNC_IDLE;
			st_q.level <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// edges come from the next level, saving a cycle of latency
	assign LEVEL = st_q.level;
	assign FELL = st_q.level && !st_d.level;
	assign ROSE = !st_q.level && st_d.level;

endmodule : link_pin_sync

module adc_device_end
	import adc_cal_pkg::*;
(
	// clock and reset (reset stands for a power cycle)
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// serial link
	adc_link_if.dev LINK,
	// converter core
	input wire logic [9:0] RAW_SAMPLE,
	input wire logic [9:0] OFFSET_MEAS,
	// status
	output logic CAL_BUSY,
	output logic CAL_DONE,
	output logic [9:0] SAMPLE_CODE
);

	dev_state_type st_q;
	dev_state_type st_d;

	logic cs_fall;
	logic cs_rise;
	logic ck_fall;
	logic [5:0] falls_next;
	logic signed [11:0] diff;
	logic [9:0] corrected;

	link_pin_sync cs_pin_i (
		.CORE_CLK(CORE_CLK),
		.RST_N(RST_N),
		.PIN(LINK.cs_n),
		.LEVEL(),
		.FELL(cs_fall),
		.ROSE(cs_rise)
	);

	link_pin_sync ck_pin_i (
		.CORE_CLK(CORE_CLK),
		.RST_N(RST_N),
		.PIN(LINK.sclk),
		.LEVEL(),
		.FELL(ck_fall),
		.ROSE()
	);

	// offset is two's complement; result clamps into the code range
	always_comb begin
		diff = $signed({2'b00, RAW_SAMPLE})
			- $signed({{2{st_q.offset_correction_store[9]}},
			st_q.offset_correction_store});
		if (diff < 12'sh000) begin
			corrected = `CODE_MIN; // RL16
		end else if (diff > $signed({2'b00, `CODE_MAX})) begin
			corrected = `CODE_MAX; // RL16
		end else begin
			corrected = diff[9:0]; // RL5
		end
	end

	always_comb begin
		st_d = st_q;
		falls_next = st_q.falls;

		if (st_q.falls != `FALLS_MAX) begin
			falls_next = st_q.falls + 6'h01;
		end

		unique case (st_q.phase)
			DEV_IDLE: begin
				st_d.sdo = 1'b0;
				st_d.sdo_oe = 1'b0;
				if (cs_fall) begin
					st_d.phase = DEV_FRAME;
					st_d.falls = 6'h00; // RL17
					st_d.sdo_oe = 1'b1;
					if (st_q.first) begin
						// nothing to convert yet; data bits stay zero
						st_d.shreg = 12'h000; // RL2
						st_d.cal_busy = 1'b1; // RL1
					end else begin
						st_d.shreg = {2'b00, corrected}; // RL15
						st_d.code = corrected; // RL5
					end
					st_d.sdo = st_d.shreg[11]; // RL15
				end
			end
			DEV_FRAME: begin
				if (cs_rise) begin
					// an unfinished calibration is simply dropped
					st_d.phase = DEV_IDLE;
					st_d.sdo = 1'b0;
					st_d.sdo_oe = 1'b0; // RL9
					st_d.cal_busy = 1'b0; // RL4 RL10
					st_d.first = 1'b0; // RL17
				end else if (ck_fall) begin
					st_d.falls = falls_next; // RL17
					// zeros fill behind, so the line sits low after bit 12
					st_d.shreg = {st_q.shreg[10:0], 1'b0}; // RL7 RL9
					st_d.sdo = st_d.shreg[11]; // RL15
					if (st_q.first) begin
						if (falls_next == `PWR_CAL_FALLS) begin
							st_d.offset_correction_store = OFFSET_MEAS; // RL1
							st_d.cal_busy = 1'b0;
							st_d.cal_done = 1'b1;
						end
					end else begin
						if (falls_next == `NORM_CAL_START) begin
							st_d.cal_busy = 1'b1; // RL8
						end
						if (falls_next == `NORM_CAL_END) begin
							st_d.offset_correction_store = OFFSET_MEAS; // RL6 RL8
							st_d.cal_busy = 1'b0;
							st_d.cal_done = 1'b1;
						end
					end
				end
			end
		endcase
	end

	// the store has no path to the serial output except via correction
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			st_q <= '0; // RL14
			st_q.first <= 1'b1; // RL17
			st_q.phase <= DEV_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign LINK.sdo = st_q.sdo;
	assign LINK.sdo_oe = st_q.sdo_oe;
	assign CAL_BUSY = st_q.cal_busy;
	assign CAL_DONE = st_q.cal_done;
	assign SAMPLE_CODE = st_q.code;

endmodule : adc_device_end
`default_nettype wire

// >>> tb/adc_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
module adc_link_properties (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// serial link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic sclk_q;
	logic first_q;
	logic [5:0] falls_q;
	// counted at the pins, ahead of the device's synchroniser
	always_ff @(posedge CORE_CLK) begin
		sclk_q <= sclk;
		if (!RST_N) begin
			first_q <= 1'b1;
			falls_q <= 6'h00;
		end else begin
			if (cs_n && falls_q != 6'h00)
				first_q <= 1'b0;
			if (cs_n)
				falls_q <= 6'h00;
			else if (sclk_q && !sclk && falls_q != 6'h3F)
				falls_q <= falls_q + 6'h01;
		end
	end
	default clocking dc @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	sequence frame_open;
		(!cs_n)[*8];
	endsequence
	sequence frame_shut;
		cs_n[*8];
	endsequence
	oe_in_frame_a: assert property (frame_open |-> sdo_oe)
		else $error("sdo not driven in frame");
	oe_released_a: assert property (frame_shut |-> !sdo_oe)
		else $error("sdo driven after deselect");
	oe_opens_a: assert property ($rose(sdo_oe) |-> !cs_n && !sdo)
		else $error("frame opened wrongly");
	oe_closes_a: assert property ($fell(sdo_oe) |-> cs_n)
		else $error("sdo released in frame");
	lead_zeros_a: assert property (
		sdo_oe && !cs_n && falls_q <= 6'h01 |-> !sdo)
		else $error("leading bit not zero");
	tail_low_a: assert property (
		sdo_oe && !cs_n && falls_q >= 6'h0D |-> !sdo)
		else $error("sdo high after twelve falls");
	quiet_start_a: assert property (first_q && sdo_oe |-> !sdo)
		else $error("data in power-up frame");
	shift_hold_a: assert property (
		$fell(sclk) && !cs_n |=> $stable(sdo)[*3])
		else $error("sdo moved too early");
endmodule : adc_link_properties
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top import adc_cal_pkg::*;;
	logic clk, rst_n, start, cal_req, busy, rv, cb, cd;
	logic [9:0] res, raw, ofs, code;
	int error_cnt = 0;
	int samples_checked = 0;
	adc_link_if link();
	adc_host_end adc_host_end_i (.CORE_CLK(clk), .RST_N(rst_n),
		.LINK(link), .START(start), .CAL_REQ(cal_req), .BUSY(busy),
		.RESULT(res), .RESULT_VALID(rv));
	adc_device_end adc_device_end_i (.CORE_CLK(clk), .RST_N(rst_n),
		.LINK(link), .RAW_SAMPLE(raw), .OFFSET_MEAS(ofs),
		.CAL_BUSY(cb), .CAL_DONE(cd), .SAMPLE_CODE(code));
	adc_link_properties adc_link_properties_i (.CORE_CLK(clk),
		.RST_N(rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
		.sdo(link.sdo), .sdo_oe(link.sdo_oe));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic [9:0] g, x);
		samples_checked++;
		if (g !== x) begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, g, x);
		end
	endtask : chk
	// one whole frame; f marks the power-up frame, which yields no result
	task automatic frame(input logic [9:0] r, e, input logic c, f);
		int n;
		logic got, cs;
		@(posedge clk);
		raw <= r;
		cal_req <= c;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		got = 1'b0;
		cs = 1'b0;
		while (n < 4 || busy !== 1'b0) begin
			@(negedge clk);
			n++;
			if (rv === 1'b1)
				got = 1'b1;
			if (cb === 1'b1)
				cs = 1'b1;
			if (n > 2000) begin
				error_cnt++;
				test_done();
			end
		end
		if (f)
			chk({9'h000, got}, 10'h000);
		else begin
			chk({9'h000, got}, 10'h001);
			chk(res, e);
			chk(code, e);
			chk({9'h000, cs}, {9'h000, c});
		end
	endtask : frame
	initial begin
		rst_n = 1'b0;
		start = 1'b0;
		cal_req = 1'b0;
		raw = 10'h000;
		ofs = 10'h005;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk({9'h000, cd}, 10'h000);
		chk(code, 10'h000);
		frame(10'h100, 10'h000, 1'b0, 1'b1);
		chk({9'h000, cd}, 10'h001);
		@(posedge clk);
		ofs <= 10'h3FE;
		frame(10'h100, 10'h0FB, 1'b0, 1'b0);
		frame(10'h003, 10'h000, 1'b0, 1'b0);
		frame(10'h3FF, 10'h3FA, 1'b1, 1'b0);
		frame(10'h3FF, 10'h3FF, 1'b0, 1'b0);
		frame(10'h200, 10'h202, 1'b0, 1'b0);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk({9'h000, cd}, 10'h000);
		frame(10'h100, 10'h000, 1'b0, 1'b1);
		test_done();
	end
endmodule : tb_top
`default_nettype wire
